// File: tmr_channel.sv
// Multi-mode 16-bit reload timer channel with an APB register port and one level interrupt.
// Assumes one 40 MHz clock, an asynchronous active-high reset and an event pin from the board.
//
// Behaviour
// (R1) A counter read while counting returns the live counter value, except at a timer or event reload instant.
// (R2) In timer mode a read at the reload instant returns the fixed value 0fff.
// (R3) In event mode a reload read returns ffff on underflow, 0000 on overflow.
// (R4) Writing the counter while halted makes the next read return that written value.
// (R5) Software rewrites the counter after stopping a free-running event count.
// (R6) One-shot abort by clearing start halts the counter and loads the reload value.
// (R7) One-shot abort drives the timer output pin low.
// (R8) One-shot abort sets the interrupt request flag.
// (R9) Entering one-shot first after reset, or from timer or event mode, sets the flag.
// (R10) Entering PWM first after reset, or from timer or event mode, sets the flag.
// (R11) Software clears the interrupt request flag after such a mode change.
// (R12) In PWM mode clearing start stops the counter.
// (R13) A PWM stop while the pin is high drives it low and sets the flag.
// (R14) A PWM stop while the pin is low keeps it low and leaves the flag alone.
// (R15) Software writes ff to the reserved system addresses at initialisation.
// (R16) The interrupt request flag stays set until software clears it.
`default_nettype none
`include "tmr_consts.svh"

module tmr_channel
    import tmr_pkg::*;
#(
    parameter int PRESCALE = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire tmr_pkg::tmr_apb_req_t apb_i,
    output tmr_pkg::tmr_apb_rsp_t apb_o,
    input wire logic event_pin_i,
    output logic timer_channel_output_pin_o,
    output logic irq_o
);
    import tmr_pkg::*;

    // The prescaler counter is eight bits wide, so larger divisions are refused at elaboration.
    if (PRESCALE < 1 || PRESCALE > 256) begin
        $error("PRESCALE must lie between 1 and 256");
    end

    localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

    tmr_state_t state_reg;
    tmr_mode_t mode_reg;
    logic free_reg;
    logic up_reg;
    logic mode_chosen_reg;
    logic [15:0] cnt_reg;
    logic [15:0] reload_reg;
    logic [7:0] pre_reg;
    logic status_reg;
    logic mask_reg;
    logic out_reg;
    logic ev_meta_reg;
    logic ev_sync_reg;
    logic ev_prev_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    logic tick;
    logic ev_edge;
    logic step;
    logic at_zero;
    logic at_ones;
    logic reload_evt;
    logic underflow;
    logic [15:0] cnt_step;
    logic pwm_out_next;
    logic setup;
    logic access;
    logic wr;
    logic wr_ctrl;
    logic wr_reload;
    logic wr_count;
    logic wr_status;
    logic wr_mask;
    logic mapped;
    tmr_mode_t new_mode;
    logic new_start;
    logic stop_req;
    logic start_req;
    logic os_abort;
    logic os_done;
    logic pwm_stop;
    logic pwm_fall;
    logic mode_irq;
    logic irq_set;
    logic [15:0] count_view;

    // Prescaler: one-cycle tick that paces timer, one-shot and PWM counting.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= `TMR_RST_PRE;
        end else if (pre_reg == PRE_LAST) begin
            pre_reg <= `TMR_RST_PRE;
        end else begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    assign tick = (pre_reg == PRE_LAST);

    // Event pin passes three flip-flops; only the second and later stages feed the edge detector.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ev_meta_reg <= 1'b0;
            ev_sync_reg <= 1'b0;
            ev_prev_reg <= 1'b0;
        end else begin
            ev_meta_reg <= event_pin_i;
            ev_sync_reg <= ev_meta_reg;
            ev_prev_reg <= ev_sync_reg;
        end
    end

    assign ev_edge = ev_sync_reg & ~ev_prev_reg;

    // APB decode; a write takes effect in the access cycle in which pready is high.
    assign setup = apb_i.psel & ~apb_i.penable;
    assign access = apb_i.psel & apb_i.penable & pready_reg;
    assign wr = access & apb_i.pwrite;
    assign wr_ctrl = wr & (apb_i.paddr == `TMR_OFF_CTRL);
    assign wr_reload = wr & (apb_i.paddr == `TMR_OFF_RELOAD);
    assign wr_count = wr & (apb_i.paddr == `TMR_OFF_COUNT);
    assign wr_status = wr & (apb_i.paddr == `TMR_OFF_STATUS);
    assign wr_mask = wr & (apb_i.paddr == `TMR_OFF_MASK);
    assign mapped = (apb_i.paddr == `TMR_OFF_CTRL) || (apb_i.paddr == `TMR_OFF_RELOAD) ||
                    (apb_i.paddr == `TMR_OFF_COUNT) || (apb_i.paddr == `TMR_OFF_STATUS) ||
                    (apb_i.paddr == `TMR_OFF_MASK);

    assign new_mode = tmr_mode_t'(apb_i.pwdata[`TMR_CTRL_MODE_HI:`TMR_CTRL_MODE_LO]);
    assign new_start = apb_i.pwdata[`TMR_CTRL_START];
    assign stop_req = wr_ctrl & ~new_start & (state_reg == TMR_ST_RUN);
    assign start_req = wr_ctrl & new_start & (state_reg == TMR_ST_IDLE);

    // Counting step and reload detection for the current mode.
    always_comb begin
        step = 1'b0;
        underflow = 1'b0;
        reload_evt = 1'b0;
        at_zero = (cnt_reg == `TMR_CNT_ZERO);
        at_ones = (cnt_reg == `TMR_CNT_ONES);
        if (state_reg == TMR_ST_RUN) begin
            step = (mode_reg == TMR_MODE_EVENT) ? ev_edge : tick;
        end
        case (mode_reg)
            TMR_MODE_TIMER: begin
                reload_evt = step & at_zero;
                underflow = reload_evt;
            end
            TMR_MODE_EVENT: begin
                underflow = step & ~up_reg & at_zero;
                reload_evt = underflow | (step & up_reg & at_ones);
            end
            TMR_MODE_ONESHOT: begin
                reload_evt = step & at_zero;
                underflow = reload_evt;
            end
            TMR_MODE_PWM: begin
                reload_evt = step & at_ones;
            end
            default: begin
                reload_evt = 1'b0;
            end
        endcase
    end

    // PWM counts up; timer, one-shot and down event counting count down.
    assign cnt_step = ((mode_reg == TMR_MODE_PWM) || ((mode_reg == TMR_MODE_EVENT) && up_reg)) ?
                      cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
    assign pwm_out_next = (cnt_step < reload_reg);

    assign os_abort = stop_req & (mode_reg == TMR_MODE_ONESHOT);
    assign os_done = reload_evt & (mode_reg == TMR_MODE_ONESHOT) & ~stop_req;
    assign pwm_stop = stop_req & (mode_reg == TMR_MODE_PWM);
    assign pwm_fall = step & (mode_reg == TMR_MODE_PWM) & out_reg & ~pwm_out_next & ~stop_req;

    // A mode write into one-shot or PWM raises the flag when it is the first choice since
    // reset or when it leaves timer or event mode.
    assign mode_irq = wr_ctrl &
                      ((new_mode == TMR_MODE_ONESHOT) || (new_mode == TMR_MODE_PWM)) &
                      (~mode_chosen_reg || (mode_reg == TMR_MODE_TIMER) ||
                       (mode_reg == TMR_MODE_EVENT)); // (R9) (R10)

    // Events that raise the interrupt request flag.
    assign irq_set = os_abort | // (R8)
                     (pwm_stop & out_reg) | // (R13)
                     mode_irq |
                     os_done | pwm_fall |
                     (reload_evt & ((mode_reg == TMR_MODE_TIMER) ||
                                    (mode_reg == TMR_MODE_EVENT)));

    // Control register: mode, start, free-run and direction; one-shot completion ends a run.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= TMR_MODE_TIMER;
            free_reg <= 1'b0;
            up_reg <= 1'b0;
            mode_chosen_reg <= 1'b0;
        end else if (wr_ctrl) begin
            mode_reg <= new_mode;
            free_reg <= apb_i.pwdata[`TMR_CTRL_FREE];
            up_reg <= apb_i.pwdata[`TMR_CTRL_UP];
            mode_chosen_reg <= 1'b1;
        end
    end

    // Run state follows the start flag; clearing it stops every mode at once.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= TMR_ST_IDLE;
        end else if (stop_req) begin
            state_reg <= TMR_ST_IDLE; // (R12)
        end else if (start_req) begin
            state_reg <= TMR_ST_RUN;
        end else if (os_done) begin
            state_reg <= TMR_ST_IDLE;
        end
    end

    // Reload register; a counter write also lands here so a later reload reuses it.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reload_reg <= `TMR_RST_RELOAD;
        end else if (wr_reload || wr_count) begin
            reload_reg <= apb_i.pwdata[15:0];
        end
    end

    // Counter. Software writes win only while halted, so a running count is never disturbed.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= `TMR_RST_CNT;
        end else if (wr_count && (state_reg == TMR_ST_IDLE)) begin
            cnt_reg <= apb_i.pwdata[15:0]; // (R4)
        end else if (os_abort) begin
            cnt_reg <= reload_reg; // (R6)
        end else if (start_req && (new_mode == TMR_MODE_ONESHOT)) begin
            cnt_reg <= reload_reg;
        end else if (start_req && (new_mode == TMR_MODE_PWM)) begin
            cnt_reg <= `TMR_CNT_ZERO;
        end else if (reload_evt && (mode_reg == TMR_MODE_PWM)) begin
            cnt_reg <= `TMR_CNT_ZERO;
        end else if (reload_evt && !((mode_reg == TMR_MODE_EVENT) && free_reg)) begin
            cnt_reg <= reload_reg;
        end else if (step && !stop_req) begin
            cnt_reg <= cnt_step; // Free-running event counting simply wraps.
        end
    end

    // Timer output pin: high while a one-shot runs, the PWM level in PWM mode, else low.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
        end else if (os_abort) begin
            out_reg <= 1'b0; // (R7)
        end else if (pwm_stop) begin
            out_reg <= 1'b0; // (R13) (R14)
        end else if (start_req && (new_mode == TMR_MODE_ONESHOT)) begin
            out_reg <= 1'b1;
        end else if (start_req && (new_mode == TMR_MODE_PWM)) begin
            out_reg <= (`TMR_CNT_ZERO < reload_reg);
        end else if (os_done) begin
            out_reg <= 1'b0;
        end else if (step && (mode_reg == TMR_MODE_PWM)) begin
            out_reg <= pwm_out_next;
        end else if (wr_ctrl && (new_mode != TMR_MODE_ONESHOT) && (new_mode != TMR_MODE_PWM)) begin
            out_reg <= 1'b0;
        end
    end

    // Interrupt request flag: write one to clear; a set in the same cycle wins over the clear.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= 1'b0;
        end else if (irq_set) begin
            status_reg <= 1'b1;
        end else if (wr_status && apb_i.pwdata[`TMR_ST_IRQ]) begin
            status_reg <= 1'b0; // (R16)
        end
    end

    // Interrupt mask and the registered level interrupt output.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_reg <= apb_i.pwdata[`TMR_ST_IRQ];
            end
            irq_o <= status_reg & mask_reg;
        end
    end

    // Counter view for reads; a timer or event reload instant shows a fixed value instead of the live count.
    always_comb begin
        count_view = cnt_reg; // (R1)
        if (reload_evt && (mode_reg == TMR_MODE_TIMER)) begin
            count_view = `TMR_RD_RELOAD_TIMER; // (R2)
        end else if (reload_evt && (mode_reg == TMR_MODE_EVENT)) begin
            count_view = underflow ? `TMR_RD_RELOAD_UNDER : `TMR_RD_RELOAD_OVER; // (R3)
        end
    end

    // APB answer: read data is captured in the setup cycle and the access ends on its first
    // cycle, so every transfer takes exactly two cycles. Unmapped addresses answer pslverr.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            pready_reg <= 1'b1;
            pslverr_reg <= ~mapped;
            prdata_reg <= 32'h0000_0000;
            if (!apb_i.pwrite) begin
                case (apb_i.paddr)
                    `TMR_OFF_CTRL: begin
                        prdata_reg <= {27'h0000000, up_reg, free_reg, mode_reg,
                                       (state_reg == TMR_ST_RUN)};
                    end
                    `TMR_OFF_RELOAD: begin
                        prdata_reg <= {16'h0000, reload_reg};
                    end
                    `TMR_OFF_COUNT: begin
                        prdata_reg <= {16'h0000, count_view};
                    end
                    `TMR_OFF_STATUS: begin
                        prdata_reg <= {31'h00000000, status_reg};
                    end
                    `TMR_OFF_MASK: begin
                        prdata_reg <= {31'h00000000, mask_reg};
                    end
                    default: begin
                        prdata_reg <= 32'h0000_0000;
                    end
                endcase
            end
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign apb_o.pready = pready_reg;
    assign apb_o.pslverr = pslverr_reg;
    assign apb_o.prdata = prdata_reg;
    assign timer_channel_output_pin_o = out_reg;
endmodule

`default_nettype wire

// File: tmr_consts.svh
// Register offsets, field positions, reset values and fixed read values of the timer channel.
// Assumes it is included by bare name from the package and the timer module.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Byte offsets of the APB registers.
`define TMR_OFF_CTRL 8'h00
`define TMR_OFF_RELOAD 8'h04
`define TMR_OFF_COUNT 8'h08
`define TMR_OFF_STATUS 8'h0c
`define TMR_OFF_MASK 8'h10

// Control register fields.
`define TMR_CTRL_START 0
`define TMR_CTRL_MODE_LO 1
`define TMR_CTRL_MODE_HI 2
`define TMR_CTRL_FREE 3
`define TMR_CTRL_UP 4

// Status and mask register field.
`define TMR_ST_IRQ 0

// Reset values.
`define TMR_RST_CNT 16'h0000
`define TMR_RST_RELOAD 16'h0000
`define TMR_RST_PRE 8'h00

// Counter limits and values returned by a read at the reload instant.
`define TMR_CNT_ZERO 16'h0000
`define TMR_CNT_ONES 16'hffff
`define TMR_RD_RELOAD_TIMER 16'h0fff
`define TMR_RD_RELOAD_UNDER 16'hffff
`define TMR_RD_RELOAD_OVER 16'h0000

`endif

// File: tmr_pkg.sv
// Types shared by the timer channel and its bench.
// Assumes tmr_consts.svh sits in the same folder.
`default_nettype none

package tmr_pkg;
    `include "tmr_consts.svh"

    // Operating modes, coded as in the control register mode field.
    typedef enum logic [1:0] {
        TMR_MODE_TIMER = 2'b00,
        TMR_MODE_EVENT = 2'b01,
        TMR_MODE_ONESHOT = 2'b10,
        TMR_MODE_PWM = 2'b11
    } tmr_mode_t;

    // Counting state of the channel.
    typedef enum logic {
        TMR_ST_IDLE = 1'b0,
        TMR_ST_RUN = 1'b1
    } tmr_state_t;

    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tmr_apb_req_t;

    // APB answer from the slave.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tmr_apb_rsp_t;
endpackage

`default_nettype wire

// File: tmr_channel_chk.sv
// Port checker of the timer channel: bus answers, stops and the interrupt flag.
// Assumes it is bound into tmr_channel and sees that module's ports only.
`default_nettype none
`include "tmr_consts.svh"
module tmr_channel_chk #(
    parameter int PRESCALE = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire tmr_pkg::tmr_apb_req_t apb_i,
    input wire tmr_pkg::tmr_apb_rsp_t apb_o,
    input wire logic event_pin_i,
    input wire logic timer_channel_output_pin_o,
    input wire logic irq_o
);
    import tmr_pkg::*;
    logic acc, wr_ctrl, wr_irq, map, stop, enter, pin, mask_reg;
    logic [1:0] mode_reg;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // Completed transfers; a write lands at the edge where pready is sampled.
    assign acc = apb_i.psel && apb_i.penable && apb_o.pready;
    assign wr_ctrl = acc && apb_i.pwrite && apb_i.paddr == `TMR_OFF_CTRL;
    assign wr_irq = acc && apb_i.pwrite && apb_i.paddr inside {`TMR_OFF_STATUS, `TMR_OFF_MASK};
    assign map = apb_i.paddr inside {`TMR_OFF_CTRL, `TMR_OFF_RELOAD, `TMR_OFF_COUNT,
        `TMR_OFF_STATUS, `TMR_OFF_MASK};
    assign pin = timer_channel_output_pin_o;
    // A stop keeps the mode, so that a mode change is never taken for an abort.
    assign stop = wr_ctrl && !apb_i.pwdata[0] && mode_reg[1] && apb_i.pwdata[2:1] == mode_reg;
    assign enter = wr_ctrl && apb_i.pwdata[2] && !mode_reg[1];
    // Shadow of mode and mask, taken at the same edge as the design's registers.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= 2'h0;
            mask_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                mode_reg <= apb_i.pwdata[2:1];
            end
            if (acc && apb_i.pwrite && apb_i.paddr == `TMR_OFF_MASK) begin
                mask_reg <= apb_i.pwdata[0];
            end
        end
    end
    // Bus answers, pin stops and the flag; the flag is seen through the mask only.
    pready_next_a: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
        else $error("no ready after setup");
    bad_addr_a: assert property (acc && !map |-> apb_o.pslverr && apb_o.prdata == 32'h0)
        else $error("unmapped access not refused");
    good_addr_a: assert property (acc && map |-> !apb_o.pslverr)
        else $error("mapped access refused");
    stop_low_a: assert property (stop |-> ##[1:2] !pin)
        else $error("pin not low after stop");
    abort_flag_a: assert property (stop && pin && mask_reg |-> ##[1:3] irq_o)
        else $error("no flag after stop with pin high");
    mode_flag_a: assert property (enter && mask_reg |-> ##[1:3] irq_o)
        else $error("no flag after mode entry");
    irq_hold_a: assert property (irq_o && !wr_irq && !$past(wr_irq) |=> irq_o)
        else $error("flag dropped without a clear");
    irq_mask_a: assert property (irq_o |-> $past(mask_reg))
        else $error("interrupt while masked");
    abort_c: cover property (stop && pin);
    enter_c: cover property (enter && mask_reg);
    refuse_c: cover property (acc && !map);
endmodule
bind tmr_channel tmr_channel_chk #(.PRESCALE(PRESCALE)) chk (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o), .event_pin_i(event_pin_i),
    .timer_channel_output_pin_o(timer_channel_output_pin_o), .irq_o(irq_o));
`default_nettype wire

// File: tmr_channel_bench.sv
// Self-checking bench of the timer channel; each scenario is a task over APB.
// Assumes the package, the design and its bound checker are compiled first.
`default_nettype none
`include "tmr_consts.svh"
module tmr_channel_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import tmr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic event_pin_i = 1'b0;
    logic pin_o, irq_o, rd_err;
    logic [1:0] ev_cnt = 2'h0;
    logic [31:0] rd_data;
    tmr_apb_req_t apb_i = '0;
    tmr_apb_rsp_t apb_o;
    int err_total = 0;
    int checked = 0;
    tmr_channel #(.PRESCALE(1)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(apb_i),
        .apb_o(apb_o), .event_pin_i(event_pin_i), .timer_channel_output_pin_o(pin_o),
        .irq_o(irq_o));
    // Clock at 40 MHz.
    always #12.5 clk_sys_i = ~clk_sys_i;
    // An event edge every third clock drifts against the four-clock reads.
    always @(posedge clk_sys_i) begin
        ev_cnt <= (ev_cnt == 2'h2) ? 2'h0 : ev_cnt + 2'h1;
        event_pin_i <= (ev_cnt == 2'h0);
    end
    // Verdict and end of the run.
    task automatic end_sim();
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Four-state comparisons, so that an unknown never passes.
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    // One transfer; the request is held until pready is seen at a rising edge.
    // No local limit: only the watchdog ends a wait for an answer that never comes.
    task automatic apb(input logic w, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys_i);
        apb_i.psel <= 1'b1;
        apb_i.pwrite <= w;
        apb_i.paddr <= addr;
        apb_i.pwdata <= data;
        @(posedge clk_sys_i);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (apb_o.pready !== 1'b1);
        rd_data = apb_o.prdata;
        rd_err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        cmp_word(rd_data, exp);
    endtask
    // Reset values, dropped upper bits and a refused address.
    task automatic t_reset();
        for (int a = 0; a < 20; a += 4) begin
            rd_chk(8'(a), 32'h0);
            cmp_bit(rd_err, 1'b0);
        end
        apb(1'b0, 8'h14, 32'h0);
        cmp_bit(rd_err, 1'b1);
        cmp_word(rd_data, 32'h0);
        wr(8'h14, 32'hff);
        cmp_bit(rd_err, 1'b1);
        wr(`TMR_OFF_RELOAD, 32'hdead_beef);
        rd_chk(`TMR_OFF_RELOAD, 32'h0000_beef);
        wr(`TMR_OFF_COUNT, 32'h1234);
        rd_chk(`TMR_OFF_COUNT, 32'h1234);
    endtask
    // Reads while counting are live values or the fixed value of the reload step.
    task automatic scan(input logic [15:0] v0, input logic [15:0] v1, input logic [15:0] hit);
        logic seen;
        seen = 1'b0;
        // One idle clock makes reads four clocks apart, so they drift over a three-step period.
        repeat (9) begin
            @(posedge clk_sys_i);
            apb(1'b0, `TMR_OFF_COUNT, 32'h0);
            if (rd_data === {16'h0, hit})
                seen = 1'b1;
            else if (rd_data !== {16'h0, v1})
                cmp_word(rd_data, {16'h0, v0});
        end
        cmp_bit(seen, 1'b1);
    endtask
    task automatic t_reads();
        wr(`TMR_OFF_COUNT, 32'h2);
        wr(`TMR_OFF_CTRL, 32'h1);
        scan(16'h2, 16'h1, `TMR_RD_RELOAD_TIMER);
        wr(`TMR_OFF_CTRL, 32'h2);
        wr(`TMR_OFF_COUNT, 32'h0);
        wr(`TMR_OFF_CTRL, 32'h3);
        scan(16'h0, 16'h0, `TMR_RD_RELOAD_UNDER);
        wr(`TMR_OFF_CTRL, 32'h12);
        wr(`TMR_OFF_COUNT, 32'hffff);
        wr(`TMR_OFF_CTRL, 32'h13);
        scan(16'hffff, 16'hffff, `TMR_RD_RELOAD_OVER);
        wr(`TMR_OFF_CTRL, 32'h1b);
        repeat (10) @(posedge clk_sys_i);
        wr(`TMR_OFF_CTRL, 32'h1a);
        wr(`TMR_OFF_COUNT, 32'h55);
        rd_chk(`TMR_OFF_COUNT, 32'h55);
    endtask
    // Entry into one-shot or PWM from timer or event mode raises a sticky flag.
    task automatic t_modes();
        wr(`TMR_OFF_MASK, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`TMR_OFF_CTRL, {30'h0, i[0], 1'b0});
            wr(`TMR_OFF_STATUS, 32'h1);
            wr(`TMR_OFF_CTRL, {29'h0, 1'b1, i[1], 1'b0});
            rd_chk(`TMR_OFF_STATUS, 32'h1);
            repeat (8) @(posedge clk_sys_i);
            cmp_bit(irq_o, 1'b1);
            wr(`TMR_OFF_STATUS, 32'h1);
            repeat (2) @(posedge clk_sys_i);
            cmp_bit(irq_o, 1'b0);
        end
    endtask
    // One-shot abort in mid-count, then the flag masked while still set.
    task automatic t_oneshot();
        wr(`TMR_OFF_COUNT, 32'h40);
        wr(`TMR_OFF_CTRL, 32'h4);
        wr(`TMR_OFF_STATUS, 32'h1);
        wr(`TMR_OFF_CTRL, 32'h5);
        repeat (4) @(posedge clk_sys_i);
        cmp_bit(pin_o, 1'b1);
        wr(`TMR_OFF_CTRL, 32'h4);
        repeat (2) @(posedge clk_sys_i);
        cmp_bit(pin_o, 1'b0);
        cmp_bit(irq_o, 1'b1);
        rd_chk(`TMR_OFF_COUNT, 32'h40);
        rd_chk(`TMR_OFF_COUNT, 32'h40);
        wr(`TMR_OFF_MASK, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        cmp_bit(irq_o, 1'b0);
        rd_chk(`TMR_OFF_STATUS, 32'h1);
        wr(`TMR_OFF_MASK, 32'h1);
    endtask
    // PWM stop with the pin high, then with the pin low.
    task automatic t_pwm();
        logic [31:0] first;
        wr(`TMR_OFF_CTRL, 32'h6);
        wr(`TMR_OFF_COUNT, 32'h30);
        wr(`TMR_OFF_CTRL, 32'h7);
        wr(`TMR_OFF_STATUS, 32'h1);
        cmp_bit(pin_o, 1'b1);
        wr(`TMR_OFF_CTRL, 32'h6);
        repeat (2) @(posedge clk_sys_i);
        cmp_bit(pin_o, 1'b0);
        rd_chk(`TMR_OFF_STATUS, 32'h1);
        first = rd_data;
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        first = rd_data;
        rd_chk(`TMR_OFF_COUNT, first);
        wr(`TMR_OFF_COUNT, 32'h4);
        wr(`TMR_OFF_CTRL, 32'h7);
        repeat (12) @(posedge clk_sys_i);
        wr(`TMR_OFF_STATUS, 32'h1);
        cmp_bit(pin_o, 1'b0);
        wr(`TMR_OFF_CTRL, 32'h6);
        repeat (2) @(posedge clk_sys_i);
        cmp_bit(pin_o, 1'b0);
        rd_chk(`TMR_OFF_STATUS, 32'h0);
    endtask
    // A second reset, then PWM as the first mode chosen.
    task automatic t_rereset();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_chk(`TMR_OFF_MASK, 32'h0);
        wr(`TMR_OFF_CTRL, 32'h6);
        rd_chk(`TMR_OFF_STATUS, 32'h1);
    endtask
    // Main sequence after a reset of twelve clocks.
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_reads();
        t_modes();
        t_oneshot();
        t_pwm();
        t_rereset();
        end_sim();
    end
    // Watchdog well beyond the few hundred clocks the run needs.
    initial begin
        #500000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
